// ### logic/ssp_port_serial.sv
// Serial byte port flags and data with the shared eight-pin port.
// Assumes an Avalon-MM master on core_clk; pins and serial units outside.
`timescale 1ns/1ns
module ssp_port_serial #(
   parameter int SCK_HALF = ssp_pkg::SCK_HALF_DEFAULT
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [ssp_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Shared pins
   input wire logic [7:0] ps_in,
   output logic [7:0] ps_out,
   output logic [7:0] ps_oe_n,
   output logic [7:0] pullup_en,
   output logic [7:0] reduce_drive,
   // Asynchronous serial units
   input wire logic [1:0] sci_rx_own,
   input wire logic [1:0] sci_tx_own,
   input wire logic [1:0] sci_txd,
   // Interrupt
   output logic serial_irq
);
   import ssp_pkg::*;

   localparam int DW = $clog2(SCK_HALF + 1);

   if (SCK_HALF < 1) begin : g_bad_half
      $error("SCK_HALF must be at least one");
   end

   typedef struct packed {
      logic [7:0] ctrl;
      logic transfer_done_flag;
      logic write_collision_flag;
      logic mode_fault_flag;
      logic arm_transfer_done_flag;
      logic arm_write_collision_flag;
      logic arm_mode_fault_flag;
      logic [7:0] latch;
      logic [7:0] ddr;
      logic [7:0] pull_drive;
      logic [7:0] rx_buf;
      logic ack;
      logic [7:0] rdata;
      logic [DW-1:0] div;
      logic sck_act;
      logic [7:0] pin_meta;
      logic [7:0] pin_sync;
      logic sck_prev;
   } ssp_main_t;

   ssp_main_t st;
   ssp_main_t next_st;

   function automatic logic sel(input logic [7:0] a, input logic [7:0] r);
      sel = (a == r);
   endfunction

   function automatic logic [7:0] grp(input logic [2:0] g);
      grp = {{4{g[2]}}, {2{g[1]}}, {2{g[0]}}};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   logic req;
   logic acc;
   logic [7:0] idx;
   logic data_acc;
   logic wr_data;
   logic rd_sts;
   logic wr_ctrl;
   logic master;
   logic spe_eff;
   logic cpol;
   logic sh_busy;
   logic sh_done;
   logic sh_out;
   logic [7:0] sh_rx;
   logic sh_load;
   logic sh_start;
   logic sh_abort;
   logic write_collision_flag_set;
   logic mode_fault_flag_set;
   logic tick;
   logic sck_lvl;
   logic lead;
   logic trail;
   logic [7:0] drv;
   logic [7:0] val;
   logic [3:0] sci_drv;
   logic [3:0] sci_val;
   logic [7:0] status_byte;

   assign req = avs_read | avs_write;
   assign acc = req & st.ack;
   assign idx = avs_address[ADDR_W-1:2];
   assign data_acc = acc & sel(idx, IDX_DATA);
   assign wr_data = data_acc & avs_write;
   assign rd_sts = acc & avs_read & sel(idx, IDX_STATUS);
   assign wr_ctrl = acc & avs_write & sel(idx, IDX_CTRL_ONE);
   assign avs_waitrequest = req & ~st.ack;
   assign avs_readdata = {24'h000000, st.rdata};

   assign master = st.ctrl[CTL_MASTER];
   assign spe_eff = st.ctrl[CTL_SYS_EN] & ~st.mode_fault_flag;
   assign cpol = st.ctrl[CTL_CPOL];

   ////////////////////////////////////////////////////////////////////////////
   // Transfer control
   // collision drops the write
   assign write_collision_flag_set = wr_data & sh_busy;
   assign sh_load = wr_data & ~sh_busy;
   assign sh_start = sh_load & master & spe_eff;
   assign mode_fault_flag_set = master & st.ctrl[CTL_SYS_EN] & ~st.ddr[PIN_SEL] & ~st.pin_sync[PIN_SEL];
   assign sh_abort = ~spe_eff | (~master & st.pin_sync[PIN_SEL]);
   assign tick = sh_busy & master & (st.div == DW'(SCK_HALF - 1));
   assign sck_lvl = st.pin_sync[PIN_SCK] ^ cpol;
   assign lead = master ? (tick & ~st.sck_act) : (~st.pin_sync[PIN_SEL] & sck_lvl & ~st.sck_prev);
   assign trail = master ? (tick & st.sck_act) : (~st.pin_sync[PIN_SEL] & ~sck_lvl & st.sck_prev);

   ssp_shifter #(
      .BITS(8)
   ) u_shifter (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .cpha(st.ctrl[CTL_CPHA]),
      .lsb_first(st.ctrl[CTL_LSB_FIRST]),
      .load(sh_load),
      .load_data(avs_writedata[7:0]),
      .start(sh_start),
      .abort(sh_abort),
      .lead(lead & spe_eff),
      .trail(trail & spe_eff),
      .in_bit(master ? st.pin_sync[PIN_MISO] : st.pin_sync[PIN_MOSI]),
      .out_bit(sh_out),
      .busy(sh_busy),
      .done(sh_done),
      .rx_data(sh_rx)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin direction and drive
   // receiver pins forced input
   for (genvar u = 0; u < 2; u++) begin : g_sci
      assign sci_drv[2*u] = st.ddr[2*u] & ~sci_rx_own[u];
      assign sci_val[2*u] = st.latch[2*u];
      assign sci_drv[2*u+1] = st.ddr[2*u+1] | sci_tx_own[u];
      assign sci_val[2*u+1] = sci_tx_own[u] ? sci_txd[u] : st.latch[2*u+1];
   end

   always_comb begin
      drv = {st.ddr[7:4], sci_drv};
      val = {st.latch[7:4], sci_val};
      if (spe_eff) begin
         if (master) begin
            drv[PIN_MISO] = 1'b0;
            val[PIN_MOSI] = sh_out;
            val[PIN_SCK] = cpol ^ st.sck_act;
            val[PIN_SEL] = st.ctrl[CTL_SS_OUT] ? ~sh_busy : st.latch[PIN_SEL];
         end else begin
            drv[PIN_MISO] = st.ddr[PIN_MISO] & ~st.pin_sync[PIN_SEL];
            val[PIN_MISO] = sh_out;
            drv[PIN_MOSI] = 1'b0;
            drv[PIN_SCK] = 1'b0;
            drv[PIN_SEL] = 1'b0;
         end
      end
   end

   assign ps_out = val;
   assign ps_oe_n = ~drv;
   assign reduce_drive = grp(st.pull_drive[PD_DRIVE_LO+2:PD_DRIVE_LO]);
   assign pullup_en = grp(st.pull_drive[PD_PULL_LO+2:PD_PULL_LO]) & ~drv;
   assign serial_irq = st.ctrl[CTL_IRQ_EN] & (st.transfer_done_flag | st.mode_fault_flag);

   assign status_byte = {st.transfer_done_flag, st.write_collision_flag, 1'b0, st.mode_fault_flag, 4'h0};

   ////////////////////////////////////////////////////////////////////////////
   // State update
   always_comb begin
      next_st = st;
      next_st.pin_meta = ps_in;
      next_st.pin_sync = st.pin_meta;
      next_st.sck_prev = sck_lvl;
      next_st.ack = req & ~st.ack;
      next_st.div = (sh_busy & master & ~tick) ? st.div + DW'(1) : '0;
      next_st.sck_act = (sh_busy & master) ? (st.sck_act ^ tick) : 1'b0;
      if (avs_read && !st.ack) begin
         next_st.rdata = 8'h00;
         unique case (1'b1)
            sel(idx, IDX_CTRL_ONE): next_st.rdata = st.ctrl & ~({7'h00, st.mode_fault_flag} << CTL_SYS_EN);
            sel(idx, IDX_STATUS): next_st.rdata = status_byte;
            sel(idx, IDX_DATA): next_st.rdata = st.rx_buf;
            sel(idx, IDX_PORT): next_st.rdata = (drv & val) | (~drv & st.pin_sync);
            sel(idx, IDX_DIR): next_st.rdata = st.ddr;
            sel(idx, IDX_PULL_DRIVE): next_st.rdata = st.pull_drive;
            default: next_st.rdata = 8'h00;
         endcase
      end
      if (acc && avs_write) begin
         if (sel(idx, IDX_CTRL_ONE)) begin
            next_st.ctrl = avs_writedata[7:0];
         end
         if (sel(idx, IDX_PORT)) begin
            next_st.latch = avs_writedata[7:0];
         end
         if (sel(idx, IDX_DIR)) begin
            next_st.ddr = avs_writedata[7:0];
         end
         if (sel(idx, IDX_PULL_DRIVE)) begin
            next_st.pull_drive = avs_writedata[7:0];
         end
      end
      if (sh_done) begin
         next_st.rx_buf = sh_rx;
      end
      // arm on status read, event disarms
      if (rd_sts) begin
         next_st.arm_transfer_done_flag = st.transfer_done_flag & st.rdata[STS_DONE];
         next_st.arm_write_collision_flag = st.write_collision_flag & st.rdata[STS_COLL];
         next_st.arm_mode_fault_flag = st.mode_fault_flag & st.rdata[STS_FAULT];
      end
      if (data_acc && st.arm_transfer_done_flag) begin
         next_st.transfer_done_flag = 1'b0;
         next_st.arm_transfer_done_flag = 1'b0;
      end
      if (data_acc && st.arm_write_collision_flag) begin
         next_st.write_collision_flag = 1'b0;
         next_st.arm_write_collision_flag = 1'b0;
      end
      if (wr_ctrl && st.arm_mode_fault_flag) begin
         next_st.mode_fault_flag = 1'b0;
         next_st.arm_mode_fault_flag = 1'b0;
      end
      if (sh_done) begin
         next_st.transfer_done_flag = 1'b1;
         next_st.arm_transfer_done_flag = 1'b0;
      end
      if (write_collision_flag_set) begin
         next_st.write_collision_flag = 1'b1;
         next_st.arm_write_collision_flag = 1'b0;
      end
      if (mode_fault_flag_set) begin
         next_st.mode_fault_flag = 1'b1;
         next_st.arm_mode_fault_flag = 1'b0;
         next_st.ddr[7:5] = 3'b000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= '{rx_buf: st.rx_buf, ctrl: CTRL_ONE_RST, ddr: DIR_RST, pull_drive: PULL_DRIVE_RST,
                 latch: PORT_RST, default: '0};
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_write_collision_flag_on_busy: assert property (wr_data && sh_busy |=> st.write_collision_flag && !$past(sh_load))
      else $error("collision flag missing after busy write");
   a_write_collision_flag_no_irq: assert property (st.write_collision_flag && !st.transfer_done_flag && !st.mode_fault_flag |-> !serial_irq)
      else $error("collision raised interrupt");
   a_write_collision_flag_clear: assert property (data_acc && st.arm_write_collision_flag && !write_collision_flag_set |=> !st.write_collision_flag)
      else $error("collision flag not cleared");
   a_mode_fault_flag_set: assert property (master && st.ctrl[CTL_SYS_EN] && !st.ddr[PIN_SEL] && !st.pin_sync[PIN_SEL]
      |=> st.mode_fault_flag)
      else $error("mode fault not detected");
   a_mode_fault_flag_inhibit: assert property (st.ddr[PIN_SEL] && !st.mode_fault_flag |=> !st.mode_fault_flag)
      else $error("mode fault set with select pin output");
   a_mode_fault_flag_clear: assert property (wr_ctrl && st.arm_mode_fault_flag && !mode_fault_flag_set |=> !st.mode_fault_flag)
      else $error("mode fault not cleared");
   a_dir_forced: assert property ($rose(st.mode_fault_flag) |-> st.ddr[7:5] == 3'b000)
      else $error("directions not forced on fault");
   a_spe_masked: assert property (avs_read && !st.ack && sel(idx, IDX_CTRL_ONE) && st.mode_fault_flag
      |=> !avs_readdata[CTL_SYS_EN])
      else $error("enable read as one during fault");
   a_transfer_done_flag_done: assert property (sh_done |=> st.transfer_done_flag ##0 st.rx_buf == $past(sh_rx))
      else $error("done flag or buffer not updated");
   a_irq_done: assert property (sh_done && st.ctrl[CTL_IRQ_EN] && !wr_ctrl |=> serial_irq)
      else $error("no interrupt after transfer");
   a_rx_input: assert property (!(sci_rx_own[0] && !ps_oe_n[0]) && !(sci_rx_own[1] && !ps_oe_n[2]))
      else $error("receiver pin driven");
   a_tx_output: assert property (sci_tx_own[1] |-> !ps_oe_n[3] && ps_out[3] == sci_txd[1])
      else $error("transmitter pin not driven");
   a_pull_outputs: assert property ((~ps_oe_n & pullup_en) == 8'h00)
      else $error("pull-up active on output");
   a_slave_select: assert property (!master && st.ctrl[CTL_SYS_EN] |-> ps_oe_n[PIN_SEL])
      else $error("select pin driven in slave mode");
   a_master_miso: assert property (master && spe_eff |-> ps_oe_n[PIN_MISO])
      else $error("master drives its input pin");

   c_transfer: cover property (sh_start ##[1:300] sh_done);
   c_collision: cover property (write_collision_flag_set);
   c_fault: cover property (mode_fault_flag_set ##[1:100] wr_ctrl && st.arm_mode_fault_flag);
   c_slave_done: cover property (!master && sh_done);

endmodule

// ### logic/ssp_pkg.sv
// Constants for the serial byte port and the shared eight-pin port.
// Assumes a 32-bit Avalon-MM register bus with byte addresses (index times four).
package ssp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is index times four
   localparam int ADDR_W = 10;
   localparam logic [7:0] IDX_CTRL_ONE = 8'hd0;
   localparam logic [7:0] IDX_STATUS = 8'hd3;
   localparam logic [7:0] IDX_DATA = 8'hd5;
   localparam logic [7:0] IDX_PORT = 8'hd6;
   localparam logic [7:0] IDX_DIR = 8'hd7;
   localparam logic [7:0] IDX_PULL_DRIVE = 8'hd9;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTL_IRQ_EN = 7;
   localparam int CTL_SYS_EN = 6;
   localparam int CTL_MASTER = 4;
   localparam int CTL_CPOL = 3;
   localparam int CTL_CPHA = 2;
   localparam int CTL_SS_OUT = 1;
   localparam int CTL_LSB_FIRST = 0;
   localparam int STS_DONE = 7;
   localparam int STS_COLL = 6;
   localparam int STS_FAULT = 4;
   localparam int PD_DRIVE_LO = 4;
   localparam int PD_PULL_LO = 0;
   localparam int PIN_MISO = 4;
   localparam int PIN_MOSI = 5;
   localparam int PIN_SCK = 6;
   localparam int PIN_SEL = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and timing
   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] PULL_DRIVE_RST = 8'h00;
   localparam logic [7:0] PORT_RST = 8'h00;
   localparam int SCK_HALF_DEFAULT = 4;

endpackage

// ### logic/ssp_shifter.sv
// Byte shift engine: samples and shifts on serial clock edge pulses.
// Assumes lead/trail pulses come from the core_clk domain, one cycle each.
`timescale 1ns/1ns
module ssp_shifter #(
   parameter int BITS = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Control
   input wire logic cpha,
   input wire logic lsb_first,
   input wire logic load,
   input wire logic [BITS-1:0] load_data,
   input wire logic start,
   input wire logic abort,
   input wire logic lead,
   input wire logic trail,
   input wire logic in_bit,
   // Results
   output logic out_bit,
   output logic busy,
   output logic done,
   output logic [BITS-1:0] rx_data
);
   localparam int CW = $clog2(BITS + 1);

   if (BITS < 2) begin : g_bad_bits
      $error("ssp_shifter needs at least two bits");
   end

   typedef struct packed {
      logic [BITS-1:0] shreg;
      logic [CW-1:0] cnt;
      logic hold;
      logic pend;
      logic busy;
      logic done;
   } ssp_shift_t;

   ssp_shift_t st;
   ssp_shift_t next_st;
   logic sample_e;
   logic shift_e;

   function automatic logic [BITS-1:0] shift_in(input logic [BITS-1:0] r, input logic b, input logic lsb);
      shift_in = lsb ? {b, r[BITS-1:1]} : {r[BITS-2:0], b};
   endfunction

   assign sample_e = cpha ? trail : lead;
   assign shift_e = cpha ? lead : trail;

   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (load) begin
         next_st.shreg = load_data;
      end
      if (abort) begin
         next_st.cnt = '0;
         next_st.pend = 1'b0;
         next_st.busy = 1'b0;
      end else begin
         if (start || lead || trail) begin
            next_st.busy = 1'b1;
         end
         if (sample_e) begin
            next_st.cnt = st.cnt + CW'(1);
            if (cpha && st.cnt == CW'(BITS - 1)) begin
               next_st.shreg = shift_in(st.shreg, in_bit, lsb_first);
               next_st.done = 1'b1;
               next_st.busy = 1'b0;
               next_st.cnt = '0;
            end else begin
               next_st.hold = in_bit;
               next_st.pend = 1'b1;
            end
         end
         if (shift_e && st.pend) begin
            next_st.shreg = shift_in(st.shreg, st.hold, lsb_first);
            next_st.pend = 1'b0;
            if (st.cnt == CW'(BITS)) begin
               next_st.done = 1'b1;
               next_st.busy = 1'b0;
               next_st.cnt = '0;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= '{shreg: st.shreg, default: '0};
      end else begin
         st <= next_st;
      end
   end

   assign out_bit = lsb_first ? st.shreg[0] : st.shreg[BITS-1];
   assign busy = st.busy;
   assign done = st.done;
   assign rx_data = st.shreg;

endmodule

// ### test/ssp_slave_model.sv
// Behavioural far-side serial slave for the shared port bench.
// Assumes clock idle low, sampling on the rising edge, select framing.
`timescale 1ns/1ns
module ssp_slave_model (
   // Pins
   input wire logic sel_n,
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   // Bench side
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   logic [7:0] shift = 8'h00;
   logic last_bit = 1'b0;
   always @(negedge sel_n) shift = tx_byte;
   always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
   always @(negedge sck) if (!sel_n) shift = {shift[6:0], 1'b0};
   always @(posedge sel_n) last_bit = shift[7];
   // Released line shows inverse of last bit
   assign miso = sel_n ? ~last_bit : shift[7];
endmodule

// ### test/ssp_port_serial_tb.sv
// Bench for the serial byte port and the shared eight-pin port.
// Assumes the slave model on pins 7..4; other pins driven by the bench.
`timescale 1ns/1ns
module ssp_port_serial_tb;
   import ssp_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] ps_out, ps_oe_n, pullup_en, reduce_drive, pins, ext_drv, slave_rx, rd;
   logic [1:0] sci_rx_own = 2'b00;
   logic [1:0] sci_tx_own = 2'b00;
   logic [1:0] sci_txd = 2'b10;
   logic serial_irq, miso;
   int num_errors = 0;
   int cmp_count = 0;

   always #25 core_clk = ~core_clk;
   // Wire level from every driver
   assign pins = (ps_out & ~ps_oe_n) | ({ext_drv[7:5], miso, ext_drv[3:0]} & ps_oe_n);

   ssp_port_serial #(.SCK_HALF(4)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ps_in(pins), .ps_out(ps_out),
      .ps_oe_n(ps_oe_n), .pullup_en(pullup_en), .reduce_drive(reduce_drive),
      .sci_rx_own(sci_rx_own), .sci_tx_own(sci_tx_own), .sci_txd(sci_txd),
      .serial_irq(serial_irq));
   ssp_slave_model u_slave (.sel_n(pins[7]), .sck(pins[6]), .mosi(pins[5]), .miso(miso),
      .tx_byte(8'h3c), .rx_byte(slave_rx));

   ////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("errors %0d, comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic idle(input int k);
      repeat (k) @(posedge core_clk);
   endtask

   // One bus cycle; read data lands in rd
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {24'h0, wd};
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) begin
         num_errors++;
         $display("unexpected %0t bus answer missing", $time);
         end_of_test;
      end
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk(ps_oe_n, 8'hff, "oe after reset");
      chk(pullup_en | reduce_drive, 8'h00, "pull drive pins");
      bus(1'b0, IDX_DIR, 8'h00);
      chk(rd, 8'h00, "dir");
      bus(1'b0, IDX_PULL_DRIVE, 8'h00);
      chk(rd, 8'h00, "pull drive");
      bus(1'b0, 8'h10, 8'h00);
      chk(rd, 8'h00, "unmapped");
   endtask

   task automatic t_port;
      bus(1'b1, IDX_DIR, 8'h0f);
      bus(1'b1, IDX_PORT, 8'h5a);
      bus(1'b0, IDX_PORT, 8'h00);
      chk(rd, 8'hba, "port read");
      chk(ps_oe_n, 8'hf0, "oe");
      chk({4'h0, ps_out[3:0]}, 8'h0a, "latch");
      bus(1'b1, IDX_PULL_DRIVE, 8'h77);
      idle(1);
      chk(reduce_drive, 8'hff, "drive");
      chk(pullup_en, 8'hf0, "pull");
      sci_rx_own <= 2'b11;
      sci_tx_own <= 2'b11;
      bus(1'b1, IDX_DIR, 8'h05);
      idle(1);
      chk({6'h0, ps_oe_n[2], ps_oe_n[0]}, 8'h03, "rx pins");
      chk({6'h0, ps_oe_n[3], ps_oe_n[1]}, 8'h00, "tx pins");
      chk({6'h0, ps_out[3], ps_out[1]}, 8'h02, "tx data");
      chk(pullup_en, 8'hf5, "pull owned");
      sci_rx_own <= 2'b00;
      sci_tx_own <= 2'b00;
      bus(1'b1, IDX_PULL_DRIVE, 8'h00);
   endtask

   task automatic t_master;
      int n;
      bus(1'b1, IDX_DIR, 8'he0);
      bus(1'b1, IDX_CTRL_ONE, 8'hd2);
      bus(1'b1, IDX_DATA, 8'ha5);
      bus(1'b1, IDX_DATA, 8'hff);
      chk({4'h0, ps_oe_n[7:4]}, 8'h01, "serial pins");
      chk({7'h0, serial_irq}, 8'h00, "irq on collision");
      n = 0;
      rd = 8'h00;
      while (rd[STS_DONE] !== 1'b1 && n < 40) begin
         bus(1'b0, IDX_STATUS, 8'h00);
         n++;
      end
      chk(rd, 8'hc0, "status");
      chk({7'h0, serial_irq}, 8'h01, "irq on done");
      chk(slave_rx, 8'ha5, "slave byte");
      bus(1'b0, IDX_DATA, 8'h00);
      chk(rd, 8'h3c, "rx byte");
      bus(1'b0, IDX_STATUS, 8'h00);
      chk(rd, 8'h00, "flags cleared");
      bus(1'b1, IDX_CTRL_ONE, 8'hd3);
      bus(1'b1, IDX_DATA, 8'h01);
      n = 0;
      rd = 8'h00;
      while (rd[STS_DONE] !== 1'b1 && n < 40) begin
         bus(1'b0, IDX_STATUS, 8'h00);
         n++;
      end
      chk(rd, 8'h80, "lsb status");
      chk(slave_rx, 8'h80, "lsb slave byte");
      bus(1'b0, IDX_DATA, 8'h00);
      chk(rd, 8'h3c, "lsb rx byte");
      bus(1'b1, IDX_CTRL_ONE, 8'h00);
   endtask

   task automatic t_fault;
      bus(1'b1, IDX_CTRL_ONE, 8'h50);
      ext_drv <= 8'h20;
      idle(6);
      bus(1'b0, IDX_STATUS, 8'h00);
      chk(rd, 8'h00, "fault inhibited");
      bus(1'b1, IDX_DIR, 8'h60);
      idle(4);
      bus(1'b0, IDX_CTRL_ONE, 8'h00);
      chk(rd, 8'h10, "enable hidden");
      bus(1'b0, IDX_DIR, 8'h00);
      chk(rd, 8'h00, "dir forced");
      ext_drv <= 8'ha0;
      bus(1'b1, IDX_CTRL_ONE, 8'h10);
      bus(1'b0, IDX_STATUS, 8'h00);
      chk(rd, 8'h10, "fault set and kept");
      bus(1'b1, IDX_CTRL_ONE, 8'h00);
      bus(1'b0, IDX_STATUS, 8'h00);
      chk(rd, 8'h00, "fault cleared");
   endtask

   task automatic t_keep;
      rst_n <= 1'b0;
      idle(2);
      rst_n <= 1'b1;
      bus(1'b0, IDX_DATA, 8'h00);
      chk(rd, 8'h3c, "data kept");
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      ext_drv = 8'ha0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset;
      t_port;
      t_master;
      t_fault;
      t_keep;
      end_of_test;
   end
endmodule
